/* File: core/i2sap_regs.svh */
// Register addresses, field positions, reset values and clock figures
`ifndef I2SAP_REGS_SVH
`define I2SAP_REGS_SVH

// Register addresses on the APB (full byte addresses)
`define I2SAP_CTRL_ADDR    32'h4401_E000
`define I2SAP_CLKDIV_ADDR  32'h4401_E004
`define I2SAP_FRAC_ADDR    32'h4401_E008
`define I2SAP_SER_ADDR     32'h4401_E00C
`define I2SAP_EVT_ADDR     32'h4401_E010
`define I2SAP_EVTEN_ADDR   32'h4401_E014
`define I2SAP_STAT_ADDR    32'h4401_E018
`define I2SAP_DATA0_ADDR   32'h4401_E020
`define I2SAP_DATA1_ADDR   32'h4401_E024
`define I2SAP_DMA_TX_ADDR  32'h4401_E200
`define I2SAP_DMA_RX_ADDR  32'h4401_E280

// Source and default module clock, kHz
`define I2SAP_SRC_KHZ      240000
`define I2SAP_MOD_KHZ      24000

// Fractional ratio in 10.8 fixed point; 18'h3FFFF is 1023.99
`define I2SAP_FRAC_ONE     19'h00100
`define I2SAP_FRAC_RST     18'((`I2SAP_SRC_KHZ / `I2SAP_MOD_KHZ) * 256)

// Bit clock dividers: [4:0] first stage, [12:8] second stage
`define I2SAP_CLKDIV_RST   16'h0400

// Event bits
`define I2SAP_EVT_XDATA    0
`define I2SAP_EVT_XUNDRN   1
`define I2SAP_EVT_RDATA    2
`define I2SAP_EVT_ROVRN    3

// Serializer field stride and idle drive codes
`define I2SAP_SER_STRIDE   8
`define I2SAP_IDLE_LOW     2'h2
`define I2SAP_IDLE_HIGH    2'h3

// Last bit index of a slot
`define I2SAP_LAST16       5'h0F
`define I2SAP_LAST24       5'h17

`endif

/* File: core/i2sap_pkg.sv */
// Types shared by the audio serial port
package i2sap_pkg;

    typedef enum logic [1:0] {
        ROLE_OFF                    = 2'h0,
        SERIALIZER_TRANSMITTER_ROLE = 2'h1,
        SERIALIZER_RECEIVER_ROLE    = 2'h2
    } i2sap_role_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } i2sap_state_t;

    typedef struct packed {
        logic [21:0] rsv;
        logic        fs_pulse;
        logic        pad_one;
        logic        right_align;
        logic        lsb_first;
        logic        fs_pol;
        logic        bclk_pol;
        logic        slot24;
        logic        port_dma;
        logic        rx_en;
        logic        tx_en;
    } i2sap_ctrl_t;

    typedef struct packed {
        logic [1:0]  idle;
        i2sap_role_t role;
    } i2sap_ser_t;

endpackage

/* File: core/i2sap_port.sv */
// Master-mode two-slot audio serial port with APB registers
`timescale 1ns/100ps
`include "i2sap_regs.svh"

module i2sap_port
    import i2sap_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             bclk_out,
    output logic             ws_out,
    input  wire logic [1:0]  ser_in,
    output logic      [1:0]  ser_out,
    output logic      [1:0]  ser_oe,
    output logic             irq
);

    localparam int NSER = 2;

    i2sap_ctrl_t            ctrl_r;
    logic [15:0]            clkdiv_r;
    logic [17:0]            frac_r;
    i2sap_ser_t [NSER-1:0]  ser_r;
    logic [3:0]             evt_r;
    logic [3:0]             evten_r;
    logic [31:0]            txbuf_r [NSER];
    logic [31:0]            rxbuf_r [NSER];
    logic [NSER-1:0]        txv_r;
    logic [NSER-1:0]        rxv_r;
    logic                   txrr_r;
    logic                   rxrr_r;
    i2sap_state_t           state_r;
    logic [18:0]            acc_r;
    logic [4:0]             diva_r;
    logic [7:0]             divb_r;
    logic                   bclk_r;
    logic [4:0]             bit_cnt_r;
    logic                   slot_r;
    logic                   seen_r;
    logic [23:0]            txsh_r [NSER];
    logic [23:0]            rxsh_r [NSER];
    logic [NSER-1:0]        in_s1_r;
    logic [NSER-1:0]        in_s2_r;
    logic [31:0]            rd_nxt;
    logic                   err_nxt;
    logic                   run;
    logic                   mtick;
    logic                   tick_a;
    logic                   half;
    logic                   launch;
    logic                   capture;
    logic                   slot_start;
    logic [4:0]             last_bit;
    logic                   ws_lvl;
    logic                   wr;
    logic                   rd;
    logic                   tx_sel;
    logic                   rx_sel;
    logic                   dma_wr;
    logic                   dma_rd;
    logic [NSER-1:0]        tx_act;
    logic [NSER-1:0]        rx_act;
    logic [NSER-1:0]        tx_load;
    logic [NSER-1:0]        rx_pop;
    logic [NSER-1:0]        tx_take;
    logic [NSER-1:0]        rx_store;
    logic [NSER-1:0]        dout_nxt;
    logic [NSER-1:0]        oe_nxt;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bit reversal of a 16-bit sample
    function automatic logic [15:0] rev16(input logic [15:0] d);
        logic [15:0] r;
        r = 16'h0000;
        for (int k = 0; k < 16; k++) begin
            r[k] = d[15-k];
        end
        return r;
    endfunction

    // Place a sample in the slot, MSB of the slot at bit 23
    function automatic logic [23:0] fmt_tx(input logic [31:0] w, input i2sap_ctrl_t c);
        logic [15:0] d;
        logic [7:0]  pad;
        d   = c.lsb_first ? rev16(w[15:0]) : w[15:0];
        pad = {8{c.pad_one}};
        if (!c.slot24) begin
            return {d, 8'h00};
        end
        return c.right_align ? {pad, d} : {d, pad};
    endfunction

    // Recover a sample from the received slot bits
    function automatic logic [31:0] fmt_rx(input logic [23:0] s, input i2sap_ctrl_t c);
        logic [15:0] d;
        d = (c.slot24 && !c.right_align) ? s[23:8] : s[15:0];
        return {16'h0000, c.lsb_first ? rev16(d) : d};
    endfunction

    // Next serializer of a role, starting from the pointer
    function automatic logic pick(input logic p, input i2sap_ser_t [1:0] s,
                                  input i2sap_role_t want);
        return (s[p].role == want) ? p : ~p;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave

    assign wr     = psel & penable & pwrite;
    assign rd     = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign tx_sel = pick(txrr_r, ser_r, SERIALIZER_TRANSMITTER_ROLE);
    assign rx_sel = pick(rxrr_r, ser_r, SERIALIZER_RECEIVER_ROLE);

    // Read mux, sampled in the setup phase
    always_comb begin
        rd_nxt  = 32'h0000_0000;
        err_nxt = 1'b0;
        case (paddr)
            `I2SAP_CTRL_ADDR:   rd_nxt = ctrl_r;
            `I2SAP_CLKDIV_ADDR: rd_nxt = {16'h0000, clkdiv_r};
            `I2SAP_FRAC_ADDR:   rd_nxt = {14'h0000, frac_r};
            `I2SAP_SER_ADDR:    rd_nxt = {20'h00000, ser_r[1], 4'h0, ser_r[0]};
            `I2SAP_EVT_ADDR:    rd_nxt = {28'h0000000, evt_r};
            `I2SAP_EVTEN_ADDR:  rd_nxt = {28'h0000000, evten_r};
            `I2SAP_STAT_ADDR:   rd_nxt = {23'h000000, run, 2'h0, rxv_r, 2'h0, txv_r};
            `I2SAP_DATA0_ADDR:  rd_nxt = ctrl_r.port_dma ? 32'h0000_0000 : rxbuf_r[0];
            `I2SAP_DATA1_ADDR:  rd_nxt = ctrl_r.port_dma ? 32'h0000_0000 : rxbuf_r[1];
            `I2SAP_DMA_TX_ADDR: rd_nxt = 32'h0000_0000;
            `I2SAP_DMA_RX_ADDR: rd_nxt = ctrl_r.port_dma ? rxbuf_r[rx_sel] : 32'h0000_0000;
            default:            err_nxt = 1'b1;
        endcase
    end

    // Answer registered so that the access phase sees stable data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= err_nxt;
        end
    end

    // Configuration registers; presetn is the module reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= i2sap_ctrl_t'(32'h0000_0000);
            clkdiv_r <= `I2SAP_CLKDIV_RST;
            frac_r   <= `I2SAP_FRAC_RST;
            ser_r    <= '{default: i2sap_ser_t'(4'h0)};
            evten_r  <= 4'h0;
        end else if (wr) begin
            case (paddr)
                `I2SAP_CTRL_ADDR:   ctrl_r   <= i2sap_ctrl_t'({22'h000000, pwdata[9:0]});
                `I2SAP_CLKDIV_ADDR: clkdiv_r <= {3'h0, pwdata[12:8], 3'h0, pwdata[4:0]} & 16'hFF1F;
                `I2SAP_FRAC_ADDR:   frac_r   <= pwdata[17:0];
                `I2SAP_EVTEN_ADDR:  evten_r  <= pwdata[3:0];
                `I2SAP_SER_ADDR: begin
                    for (int i = 0; i < NSER; i++) begin
                        ser_r[i] <= i2sap_ser_t'(pwdata[`I2SAP_SER_STRIDE*i +: 4]);
                    end
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data paths

    assign dma_wr = wr && ctrl_r.port_dma && paddr == `I2SAP_DMA_TX_ADDR
                    && ser_r[tx_sel].role == SERIALIZER_TRANSMITTER_ROLE && !txv_r[tx_sel];
    assign dma_rd = rd && ctrl_r.port_dma && paddr == `I2SAP_DMA_RX_ADDR && rxv_r[rx_sel];

    // Path select: the other path's data registers are inert
    always_comb begin
        for (int i = 0; i < NSER; i++) begin
            tx_load[i] = (dma_wr && tx_sel == 1'(i))
                       || (wr && !ctrl_r.port_dma && !txv_r[i]
                           && ser_r[i].role == SERIALIZER_TRANSMITTER_ROLE
                           && paddr == (i == 0 ? `I2SAP_DATA0_ADDR : `I2SAP_DATA1_ADDR));
            rx_pop[i]  = (dma_rd && rx_sel == 1'(i))
                       || (rd && !ctrl_r.port_dma && rxv_r[i]
                           && paddr == (i == 0 ? `I2SAP_DATA0_ADDR : `I2SAP_DATA1_ADDR));
            tx_act[i]   = run && ctrl_r.tx_en && ser_r[i].role == SERIALIZER_TRANSMITTER_ROLE;
            rx_act[i]   = run && ctrl_r.rx_en && ser_r[i].role == SERIALIZER_RECEIVER_ROLE;
            tx_take[i]  = slot_start && tx_act[i] && txv_r[i];
            rx_store[i] = slot_start && rx_act[i] && seen_r;
        end
    end

    // Round-robin pointers advance past the serializer served
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txrr_r <= 1'b0;
            rxrr_r <= 1'b0;
        end else begin
            if (dma_wr) txrr_r <= ~tx_sel;
            if (dma_rd) rxrr_r <= ~rx_sel;
        end
    end

    // Word buffers; a store wins over a pop in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txv_r <= '0;
            rxv_r <= '0;
            for (int i = 0; i < NSER; i++) begin
                txbuf_r[i] <= 32'h0000_0000;
                rxbuf_r[i] <= 32'h0000_0000;
            end
        end else begin
            for (int i = 0; i < NSER; i++) begin
                if (tx_load[i]) begin
                    txbuf_r[i] <= pwdata;
                    txv_r[i]   <= 1'b1;
                end else if (tx_take[i]) begin
                    txv_r[i]   <= 1'b0;
                end
                if (rx_store[i]) begin
                    rxbuf_r[i] <= fmt_rx(rxsh_r[i], ctrl_r);
                    rxv_r[i]   <= 1'b1;
                end else if (rx_pop[i]) begin
                    rxv_r[i]   <= 1'b0;
                end
            end
        end
    end

    // Sticky events, cleared by writing ones; a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_r <= 4'h0;
            irq   <= 1'b0;
        end else begin
            evt_r <= (evt_r & ~((wr && paddr == `I2SAP_EVT_ADDR) ? pwdata[3:0] : 4'h0))
                   | {|(rx_store & rxv_r & ~rx_pop), |rx_store,
                      |(tx_act & ~txv_r & {NSER{slot_start}}), |tx_take};
            irq   <= |(evt_r & evten_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock generation

    assign run = state_r == ST_RUN;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: if (ctrl_r.tx_en || ctrl_r.rx_en) state_r <= ST_RUN;
                ST_RUN:  if (!ctrl_r.tx_en && !ctrl_r.rx_en) state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Fractional divider: pclk stands in for the source clock
    assign mtick = run && ({1'b0, frac_r} <= `I2SAP_FRAC_ONE
                           || acc_r + `I2SAP_FRAC_ONE >= {1'b0, frac_r});
    assign tick_a   = mtick && diva_r == clkdiv_r[4:0];
    assign half     = tick_a && divb_r == clkdiv_r[15:8];
    assign launch   = half && bclk_r;
    assign capture  = half && !bclk_r;
    assign last_bit = ctrl_r.slot24 ? `I2SAP_LAST24 : `I2SAP_LAST16;
    assign slot_start = launch && bit_cnt_r >= last_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= 19'h00000;
        end else if (!run || {1'b0, frac_r} <= `I2SAP_FRAC_ONE) begin
            acc_r <= 19'h00000;
        end else if (mtick) begin
            acc_r <= acc_r + `I2SAP_FRAC_ONE - {1'b0, frac_r};
        end else begin
            acc_r <= acc_r + `I2SAP_FRAC_ONE;
        end
    end

    // Two cascaded stages; each bit clock phase is one second-stage wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diva_r <= 5'h00;
            divb_r <= 8'h00;
            bclk_r <= 1'b0;
        end else if (!run) begin
            diva_r <= 5'h00;
            divb_r <= 8'h00;
            bclk_r <= 1'b0;
        end else if (mtick) begin
            diva_r <= tick_a ? 5'h00 : diva_r + 5'h01;
            if (tick_a) divb_r <= half ? 8'h00 : divb_r + 8'h01;
            if (half) bclk_r <= ~bclk_r;
        end
    end

    // Slot counter; two slots per frame, never stalls for data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_r <= `I2SAP_LAST16;
            slot_r    <= 1'b1;
            seen_r    <= 1'b0;
        end else if (!run) begin
            bit_cnt_r <= last_bit;
            slot_r    <= 1'b1;
            seen_r    <= 1'b0;
        end else if (launch) begin
            bit_cnt_r <= slot_start ? 5'h00 : bit_cnt_r + 5'h01;
            if (slot_start) slot_r <= ~slot_r;
            if (slot_start) seen_r <= 1'b1;
        end
    end

    // Word select leads the slot by one bit; pulse mode marks the left slot
    assign ws_lvl = ctrl_r.fs_pulse ? (bit_cnt_r >= last_bit && slot_r)
                                    : (bit_cnt_r >= last_bit ? ~slot_r : slot_r);

    ////////////////////////////////////////////////////////////////////////////////
    // Serializers

    // Pin synchroniser; only the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_s1_r <= '0;
            in_s2_r <= '0;
        end else begin
            in_s1_r <= ser_in;
            in_s2_r <= in_s1_r;
        end
    end

    // Shift registers move on the port's own bit clock phases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NSER; i++) begin
                txsh_r[i] <= 24'h000000;
                rxsh_r[i] <= 24'h000000;
            end
        end else begin
            for (int i = 0; i < NSER; i++) begin
                if (slot_start && tx_act[i]) begin
                    txsh_r[i] <= fmt_tx(txv_r[i] ? txbuf_r[i] : 32'h0000_0000, ctrl_r);
                end else if (launch) begin
                    txsh_r[i] <= {txsh_r[i][22:0], 1'b0};
                end
                if (capture && rx_act[i]) begin
                    rxsh_r[i] <= {rxsh_r[i][22:0], in_s2_r[i]};
                end
            end
        end
    end

    // Data line drive: active bit, or the programmed idle level
    always_comb begin
        for (int i = 0; i < NSER; i++) begin
            dout_nxt[i] = 1'b0;
            oe_nxt[i]   = 1'b0;
            if (tx_act[i]) begin
                dout_nxt[i] = txsh_r[i][23];
                oe_nxt[i]   = 1'b1;
            end else if (ser_r[i].role != SERIALIZER_RECEIVER_ROLE) begin
                dout_nxt[i] = ser_r[i].idle == `I2SAP_IDLE_HIGH;
                oe_nxt[i]   = ser_r[i].idle[1];
            end
        end
    end

    // Pins from flops so they cannot glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_out <= 1'b0;
            ws_out   <= 1'b0;
            ser_out  <= '0;
            ser_oe   <= '0;
        end else begin
            bclk_out <= (run && bclk_r) ^ ctrl_r.bclk_pol; // parks at once when stopped
            ws_out   <= (run && ws_lvl) ^ ctrl_r.fs_pol;
            ser_out  <= dout_nxt;
            ser_oe   <= oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_irq;
        (|(evt_r & evten_r)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled event without irq");

    property p_undrn;
        (slot_start && tx_act[0] && !txv_r[0]) |=> evt_r[`I2SAP_EVT_XUNDRN];
    endproperty
    a_undrn: assert property (p_undrn) else $error("underrun not flagged");

    property p_xdata;
        (slot_start && tx_act[0] && txv_r[0]) |=> (evt_r[`I2SAP_EVT_XDATA] && !txv_r[0]);
    endproperty
    a_xdata: assert property (p_xdata) else $error("transmit request missing");

    property p_idle_clk;
        (state_r == ST_IDLE && $stable(ctrl_r)) |=> (bclk_out == ctrl_r.bclk_pol);
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("bit clock moves while idle");

    property p_slot;
        slot_start |=> (bit_cnt_r == 5'h00 && slot_r != $past(slot_r));
    endproperty
    a_slot: assert property (p_slot) else $error("slot did not advance");

    property p_dma_rr;
        (dma_wr && ser_r[0].role == SERIALIZER_TRANSMITTER_ROLE
         && ser_r[1].role == SERIALIZER_TRANSMITTER_ROLE) |=> (txrr_r != $past(txrr_r));
    endproperty
    a_dma_rr: assert property (p_dma_rr) else $error("dma tx did not rotate");

    property p_rx_rr;
        dma_rd |=> (rxrr_r == ~$past(rx_sel));
    endproperty
    a_rx_rr: assert property (p_rx_rr) else $error("dma rx did not rotate");

    property p_idle_low;
        (!tx_act[0] && ser_r[0].role != SERIALIZER_RECEIVER_ROLE
         && ser_r[0].idle == `I2SAP_IDLE_LOW) |=> (!ser_out[0] && ser_oe[0]);
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("idle low not driven");

    property p_rxstore;
        (slot_start && rx_act[1] && seen_r) |=> rxv_r[1];
    endproperty
    a_rxstore: assert property (p_rxstore) else $error("received word not stored");

endmodule

/* File: tb/i2sap_codec.sv */
// Slave codec model: captures right word, streams a pattern back
`timescale 1ns/100ps

module i2sap_codec (
    input  wire logic        bclk,
    input  wire logic        ws,
    input  wire logic        sdi,
    output logic             sdo,
    output logic [15:0]      rword,
    output logic [15:0]      sword,
    output logic             rdone
);
    logic        ws_q = 1'b0;
    logic [15:0] osh  = 16'h0000;
    logic [15:0] sh   = 16'h0000;
    logic [15:0] pat  = 16'hC3A5;

    // Ws flips one bit early, so the edge that sees it carries the last bit
    always @(posedge bclk) begin
        ws_q <= ws;
        sh   <= {sh[14:0], sdi};
        osh  <= {osh[14:0], sdo};
        if (ws_q && !ws) begin
            rword <= {sh[14:0], sdi};
            sword <= {osh[14:0], sdo};
            rdone <= 1'b1;
        end
    end

    // Pattern shifts its inverted top bit back in each bit, so it repeats every 32 bits
    initial sdo = 1'b0;
    always @(negedge bclk) begin
        sdo <= pat[15];
        pat <= {pat[14:0], ~pat[15]};
    end
endmodule

/* File: tb/i2sap_port_tb.sv */
// Self-checking bench for the audio serial port
`timescale 1ns/100ps
`include "i2sap_regs.svh"

module i2sap_port_tb;
    import i2sap_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, wa, wb, seed = 32'h42;
    logic        pready, pslverr, bclk_out, ws_out, irq, sdo, rdone, err;
    logic [1:0]  ser_out, ser_oe;
    logic [15:0] rword, sword;
    int          n_fail = 0, checks = 0;

    i2sap_port i2sap_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bclk_out(bclk_out), .ws_out(ws_out), .ser_in({sdo, ~sdo}),
        .ser_out(ser_out), .ser_oe(ser_oe), .irq(irq));
    i2sap_codec i2sap_codec_i (.bclk(bclk_out), .ws(ws_out), .sdi(ser_out[0]), .sdo(sdo),
        .rword(rword), .sword(sword), .rdone(rdone));

    // 25 MHz clock
    always #20 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Xorshift stepping of the seed
    function automatic void nr();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
    endfunction

    // APB transfer held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(rd, exp);
    endtask

    task automatic report_and_stop();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`I2SAP_CTRL_ADDR, 32'h0);
        rdchk(`I2SAP_CLKDIV_ADDR, 32'h0400);
        rdchk(`I2SAP_FRAC_ADDR, 32'h0A00);
        rdchk(`I2SAP_SER_ADDR, 32'h0);
        rdchk(`I2SAP_EVT_ADDR, 32'h0);
        rdchk(`I2SAP_DMA_TX_ADDR, 32'h0);
        rdchk(32'h4401_E100, 32'h0);
        cmp({31'h0, err}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            nr();
            apb(1'b1, `I2SAP_CLKDIV_ADDR, seed);
            rdchk(`I2SAP_CLKDIV_ADDR, seed & 32'h1F1F);
            apb(1'b1, `I2SAP_FRAC_ADDR, seed);
            rdchk(`I2SAP_FRAC_ADDR, seed & 32'h3FFFF);
        end
        // DMA path: two words land on alternate transmit serializers
        apb(1'b1, `I2SAP_SER_ADDR, 32'h0101);
        apb(1'b1, `I2SAP_CTRL_ADDR, 32'h4);
        apb(1'b1, `I2SAP_DMA_TX_ADDR, seed);
        rdchk(`I2SAP_STAT_ADDR, 32'h1);
        apb(1'b1, `I2SAP_DMA_TX_ADDR, seed);
        rdchk(`I2SAP_STAT_ADDR, 32'h3);
        // Reset with both transmit words pending brings the dividers back
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`I2SAP_CLKDIV_ADDR, 32'h0400);
        rdchk(`I2SAP_STAT_ADDR, 32'h0);
        // Serializer 0 transmits, 1 receives, CPU path, 16-bit slots
        apb(1'b1, `I2SAP_SER_ADDR, 32'h0209);
        apb(1'b1, `I2SAP_EVTEN_ADDR, 32'h1);
        nr();
        wa = seed;
        nr();
        wb = seed;
        apb(1'b1, `I2SAP_DATA0_ADDR, wa);
        // Default dividers: module clock ten bit clocks, 32 bits per frame
        apb(1'b1, `I2SAP_CTRL_ADDR, 32'h3);
        rd = 32'h0;
        for (int t = 0; t < 60 && rd[0] !== 1'b1; t++)
            apb(1'b0, `I2SAP_EVT_ADDR, 32'h0);
        cmp({31'h0, irq}, 32'h1);
        apb(1'b1, `I2SAP_DATA0_ADDR, wb);
        apb(1'b1, `I2SAP_EVT_ADDR, 32'h1);
        for (int t = 0; t < 4000 && rdone !== 1'b1; t++)
            @(posedge pclk);
        cmp({16'h0, rword}, {16'h0, wb[15:0]});
        // Right word lands in the receive buffer at the next slot start
        repeat (150) @(posedge pclk);
        rdchk(`I2SAP_DATA1_ADDR, {16'h0, sword});
        repeat (250) @(posedge pclk);
        apb(1'b0, `I2SAP_EVT_ADDR, 32'h0);
        cmp(rd & 32'h6, 32'h6);
        apb(1'b1, `I2SAP_CTRL_ADDR, 32'h0);
        apb(1'b1, `I2SAP_EVT_ADDR, 32'hF);
        rdchk(`I2SAP_EVT_ADDR, 32'h0);
        repeat (3) @(posedge pclk);
        cmp({29'h0, irq, ser_oe[0], ser_out[0]}, 32'h2);
        report_and_stop();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        report_and_stop();
    end
endmodule
